// >>> design/swp_pkg.sv
/*
 Constants, opcodes, field positions and types of the serial flash
 write-protection block. Assumes a 100 MHz core clock and an SPI host.
*/
// Notes on behaviour
// RQ1: After reset the command engine sits idle; no program or erase is pending.
// RQ2: Memory changes only after a complete, well-formed command frame.
// RQ3: A frame not ending on a byte boundary is dropped; hosts send whole bytes.
// RQ4: Data-changing commands need the write latch, set by write-enable first.
// RQ5: Reset and completion of listed write commands clear the write latch.
// RQ6: In deep sleep only release and read-signature are obeyed.
// RQ7: Protect-level bits mark a read-only region; program and erase refused there.
// RQ8: Bottom-select clear: levels 1-6 guard top 1..32 blocks, 7-15 guard all.
// RQ9: Bottom-select set: levels 1-6 guard lowest 1..32 blocks, 7-15 guard all.
// RQ10: Status lock with protect pin low freezes level bits and status lock.
// RQ11: Quad mode disables pin protection; the pin carries data then.
// RQ12: In individual mode single lock and unlock act on one addressed block.
// RQ13: In individual mode global lock and unlock act on every block.
// RQ14: Chip erase runs only when all four protect-level bits are zero.
// RQ15: Security bit 0 shows whether the secured area was factory locked.
// RQ16: Host programs secured area between enter and exit secured-mode commands.
// RQ17: Security write sets the customer lock, security bit 1.
// RQ18: Factory and customer locks, once set, never clear; here reset clears both.
// RQ19: In secured mode the main array cannot be reached.
// RQ20: Secured offsets 000-00F are serial number, 010-1FF customer area.
// RQ21: Refused protected writes leave memory alone but still clear the latch.
// RQ22: Reset selects protect-level mode, not individual block mode.
package swp_pkg;
	typedef logic [7:0] swp_byte_t;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SHIFT = 2'b01, ST_EXEC = 2'b11} swp_state_t;
	typedef enum logic [2:0] {
		KIND_PROGRAM  = 3'h0,
		KIND_WIPE_4K  = 3'h1,
		KIND_ERASE_32 = 3'h2,
		KIND_ERASE_64 = 3'h3,
		KIND_CHIP     = 3'h4
	} swp_kind_t;

	localparam swp_byte_t OP_WRITE_ENABLE       = 8'h06;
	localparam swp_byte_t OP_WRITE_DISABLE      = 8'h04;
	localparam swp_byte_t OP_STATUS_WRITE       = 8'h01;
	localparam swp_byte_t OP_PAGE_PROGRAM       = 8'h02;
	localparam swp_byte_t OP_QUAD_PAGE_PROGRAM  = 8'h38;
	localparam swp_byte_t OP_CONT_PROGRAM       = 8'hAD;
	localparam swp_byte_t OP_FOUR_KB_WIPE       = 8'h20;
	localparam swp_byte_t OP_HALF_BLOCK_ERASE   = 8'h52;
	localparam swp_byte_t OP_BLOCK_ERASE        = 8'hD8;
	localparam swp_byte_t OP_CHIP_ERASE         = 8'h60;
	localparam swp_byte_t OP_DEEP_SLEEP         = 8'hB9;
	localparam swp_byte_t OP_SLEEP_RELEASE      = 8'hAB;
	localparam swp_byte_t OP_SINGLE_BLOCK_LOCK  = 8'h36;
	localparam swp_byte_t OP_SINGLE_BLOCK_UNLK  = 8'h39;
	localparam swp_byte_t OP_GLOBAL_LOCK        = 8'h7E;
	localparam swp_byte_t OP_GLOBAL_UNLOCK      = 8'h98;
	localparam swp_byte_t OP_PERMANENT_LOCK     = 8'h64;
	localparam swp_byte_t OP_LOCK_REG_WRITE     = 8'h2D;
	localparam swp_byte_t OP_PROTECTION_SELECT  = 8'h68;
	localparam swp_byte_t OP_ENTER_SECURED      = 8'hB1;
	localparam swp_byte_t OP_EXIT_SECURED       = 8'hC1;
	localparam swp_byte_t OP_SECURITY_REG_WRITE = 8'h2F;

	localparam logic [2:0] LEN_CMD    = 3'h1;
	localparam logic [2:0] LEN_STATUS = 3'h2;
	localparam logic [2:0] LEN_ADDR   = 3'h4;
	localparam logic [2:0] LEN_PROG   = 3'h5;

	localparam logic [7:0] REG_STATUS   = 8'h00;
	localparam logic [7:0] REG_CTRL     = 8'h04;
	localparam logic [7:0] REG_SECURITY = 8'h08;

	localparam int ST_LOCK_BIT  = 7;
	localparam int ST_TB_BIT    = 6;
	localparam int ST_LEVEL_LSB = 2;
	localparam logic [3:0] LEVEL_ALL    = 4'h7;
	localparam logic [3:0] PIN_RST      = 4'hA;
	localparam logic [8:0] CUSTOMER_OFF = 9'h010;

	function automatic logic [2:0] need_len(input swp_byte_t op);
		case (op)
			OP_STATUS_WRITE: need_len = LEN_STATUS;
			OP_PAGE_PROGRAM, OP_QUAD_PAGE_PROGRAM, OP_CONT_PROGRAM: need_len = LEN_PROG;
			OP_FOUR_KB_WIPE, OP_HALF_BLOCK_ERASE, OP_BLOCK_ERASE,
			OP_SINGLE_BLOCK_LOCK, OP_SINGLE_BLOCK_UNLK: need_len = LEN_ADDR;
			default: need_len = LEN_CMD;
		endcase
	endfunction

	function automatic logic clears_latch(input swp_byte_t op);
		case (op)
			OP_WRITE_DISABLE, OP_STATUS_WRITE, OP_PAGE_PROGRAM, OP_QUAD_PAGE_PROGRAM,
			OP_CONT_PROGRAM, OP_FOUR_KB_WIPE, OP_HALF_BLOCK_ERASE, OP_BLOCK_ERASE,
			OP_CHIP_ERASE, OP_SINGLE_BLOCK_LOCK, OP_SINGLE_BLOCK_UNLK, OP_GLOBAL_LOCK,
			OP_GLOBAL_UNLOCK, OP_PERMANENT_LOCK, OP_LOCK_REG_WRITE: clears_latch = 1'b1;
			default: clears_latch = 1'b0;
		endcase
	endfunction

	function automatic logic needs_latch(input swp_byte_t op);
		needs_latch = (clears_latch(op) && op != OP_WRITE_DISABLE)
			|| op == OP_PROTECTION_SELECT || op == OP_SECURITY_REG_WRITE;
	endfunction
endpackage

// >>> design/swp_prot_if.sv
/*
 Carrier between the protection controller and its level decoder.
 Assumes both ends sit in the same clock domain; purely combinational.
*/
`timescale 1ns/1ns
interface swp_prot_if;
	logic [3:0] level;
	logic       top_bottom;
	logic [5:0] blk;
	logic       hit;
	modport ctl (output level, output top_bottom, output blk, input hit);
	modport dec (input level, input top_bottom, input blk, output hit);
endinterface

// >>> design/swp_sync3.sv
/*
 Three-stage pin synchroniser with agreement filter.
 Assumes asynchronous pin inputs; output moves when stages two and three agree.
*/
`timescale 1ns/1ns
module swp_sync3 (
	// Clock and reset
	input  wire  logic       clk,
	input  wire  logic       rst_n,
	// Pins and filtered levels
	input  wire  logic [3:0] d,
	output logic       [3:0] q
);
	import swp_pkg::*;
	logic [3:0] s1;
	logic [3:0] s2;
	logic [3:0] s3;
	logic [3:0] agree;
	assign agree = ~(s2 ^ s3);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= PIN_RST;
			s2 <= PIN_RST;
			s3 <= PIN_RST;
			q  <= PIN_RST;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			q  <= (s3 & agree) | (q & ~agree);
		end
	end
endmodule

// >>> design/swp_level_decode.sv
/*
 Protect-level decoder: tells whether a 64 KB block lies in the guarded region.
 Assumes level and top/bottom select come from the status bits.
*/
`timescale 1ns/1ns
module swp_level_decode (
	// Level, select and block in; hit out
	swp_prot_if.dec p
);
	import swp_pkg::*;
	logic [6:0] span;
	logic [6:0] blk_w;
	logic       in_top;
	logic       in_bottom;
	assign span      = 7'h01 << (p.level[2:0] - 3'h1);
	assign blk_w     = {1'b0, p.blk};
	assign in_top    = blk_w >= (7'h40 - span);
	assign in_bottom = blk_w < span;
	assign p.hit     = (p.level == 4'h0) ? 1'b0 :
		(p.level >= LEVEL_ALL) ? 1'b1 :
		(p.top_bottom ? in_bottom : in_top);  // RQ8 RQ9
endmodule

// >>> design/swp_top.sv
/*
 Write-protection controller of a serial flash.
 Samples the SPI pins on the core clock, frames commands, keeps the write
 latch, deep sleep, protect levels, block locks and secured-area locks, and
 issues one-cycle program or erase requests to the memory core.
 Assumes a 100 MHz clock well above the serial clock, and a register port
 driven by local software.
*/
`timescale 1ns/1ns
module swp_top (
	// Clock and reset
	input  wire  logic        clk,
	input  wire  logic        rst_n,
	// Serial pins
	input  wire  logic        sclk,
	input  wire  logic        cs_n,
	input  wire  logic        si,
	input  wire  logic        write_protect_pin,
	// Factory strap
	input  wire  logic        factory_lock_strap,
	// Register port
	input  wire  logic [7:0]  reg_addr,
	input  wire  logic [31:0] reg_wdata,
	input  wire  logic        reg_wr,
	input  wire  logic        reg_rd,
	output logic       [31:0] reg_rdata,
	// Memory core request
	output logic              op_go,
	output swp_pkg::swp_kind_t op_kind,
	output logic       [21:0] op_addr,
	output logic       [7:0]  op_data,
	output logic              op_secured,
	// State
	output logic              write_latch,
	output logic              deep_sleep,
	output logic              secured_mode
);
	import swp_pkg::*;

	////////////////////////////////////////
	// Pin sampling

	logic [3:0] pins;
	logic       sclk_q;
	logic       cs_q;
	logic       sclk_rise;
	logic       cs_fall;
	logic       cs_rise;

	swp_sync3 u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({write_protect_pin, si, cs_n, sclk}),
		.q     (pins)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q <= 1'b0;
			cs_q   <= 1'b1;
		end else begin
			sclk_q <= pins[0];
			cs_q   <= pins[1];
		end
	end

	assign sclk_rise = pins[0] & ~sclk_q;
	assign cs_fall   = ~pins[1] & cs_q;
	assign cs_rise   = pins[1] & ~cs_q;

	////////////////////////////////////////
	// Frame capture

	swp_state_t state;
	swp_state_t next_state;
	logic [2:0] bit_cnt;
	logic [2:0] byte_cnt;
	logic [7:0] shift;
	swp_byte_t  frame [0:4];
	logic [7:0] next_shift;
	logic       byte_done;

	assign next_shift = {shift[6:0], pins[2]};
	assign byte_done  = (state == ST_SHIFT) && sclk_rise && bit_cnt == 3'h7;

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: if (cs_fall) next_state = ST_SHIFT;
			ST_SHIFT: if (cs_rise) next_state = ST_EXEC;
			ST_EXEC: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;  // RQ1
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt  <= 3'h0;
			byte_cnt <= 3'h0;
			shift    <= 8'h00;
		end else if (state == ST_IDLE) begin
			bit_cnt  <= 3'h0;
			byte_cnt <= 3'h0;
		end else if (state == ST_SHIFT && sclk_rise) begin
			bit_cnt <= bit_cnt + 3'h1;
			shift   <= next_shift;
			if (byte_done && byte_cnt != LEN_PROG) begin
				byte_cnt <= byte_cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 5; i++) begin
				frame[i] <= 8'h00;
			end
		end else if (byte_done && byte_cnt != LEN_PROG) begin
			frame[byte_cnt] <= next_shift;
		end
	end

	////////////////////////////////////////
	// Command qualification

	swp_byte_t   op;
	logic [21:0] addr;
	logic [7:0]  st_byte;
	logic        exec;
	logic        frame_ok;
	logic        cmd_ok;
	logic        allowed;
	logic        hw_frozen;
	logic        quad_mode;
	logic        status_lock;
	logic        top_bottom;
	logic [3:0]  level;
	logic        protection_select_cmd;
	logic        fac_lock;
	logic        cust_lock;
	logic [63:0] blk_lock;
	logic        prot_hit;
	logic        sec_locked;
	logic        is_prog;
	logic        is_erase;

	assign op       = frame[0];
	assign addr     = {frame[1][5:0], frame[2], frame[3]};
	assign st_byte  = frame[1];
	assign exec     = state == ST_EXEC;
	assign frame_ok = bit_cnt == 3'h0 && byte_cnt >= need_len(op);  // RQ3 RQ2
	assign cmd_ok   = exec && frame_ok
		&& (!deep_sleep || op == OP_SLEEP_RELEASE);  // RQ6
	assign allowed  = cmd_ok && (!needs_latch(op) || write_latch);  // RQ4
	// Pin protection is void in quad mode since the pin carries data
	assign hw_frozen = status_lock && !pins[3] && !quad_mode;  // RQ10 RQ11

	swp_prot_if prot ();
	assign prot.level      = level;
	assign prot.top_bottom = top_bottom;
	assign prot.blk        = addr[21:16];
	swp_level_decode u_dec (.p(prot.dec));

	assign prot_hit   = protection_select_cmd ? blk_lock[addr[21:16]] : prot.hit;  // RQ7 RQ12
	assign sec_locked = (addr[8:0] < CUSTOMER_OFF) ? fac_lock : cust_lock;  // RQ20
	assign is_prog    = op == OP_PAGE_PROGRAM || op == OP_QUAD_PAGE_PROGRAM
		|| op == OP_CONT_PROGRAM;
	assign is_erase   = op == OP_FOUR_KB_WIPE || op == OP_HALF_BLOCK_ERASE
		|| op == OP_BLOCK_ERASE || op == OP_CHIP_ERASE;

	////////////////////////////////////////
	// Write latch and power mode

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			write_latch <= 1'b0;  // RQ5
		end else if (cmd_ok && op == OP_WRITE_ENABLE) begin
			write_latch <= 1'b1;  // RQ4
		end else if (cmd_ok && clears_latch(op)) begin
			write_latch <= 1'b0;  // RQ5 RQ21
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			deep_sleep <= 1'b0;
		end else if (cmd_ok && op == OP_DEEP_SLEEP) begin
			deep_sleep <= 1'b1;
		end else if (cmd_ok && op == OP_SLEEP_RELEASE) begin
			deep_sleep <= 1'b0;  // RQ6
		end
	end

	////////////////////////////////////////
	// Status bits

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level       <= 4'h0;
			status_lock <= 1'b0;
			top_bottom  <= 1'b0;
		end else if (allowed && op == OP_STATUS_WRITE) begin
			top_bottom <= st_byte[ST_TB_BIT];
			if (!hw_frozen) begin
				level       <= st_byte[ST_LEVEL_LSB +: 4];  // RQ10
				status_lock <= st_byte[ST_LOCK_BIT];
			end
		end
	end

	////////////////////////////////////////
	// Individual block locks

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			protection_select_cmd <= 1'b0;  // RQ22
		end else if (allowed && op == OP_PROTECTION_SELECT) begin
			protection_select_cmd <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			blk_lock <= 64'h0000_0000_0000_0000;
		end else if (allowed && protection_select_cmd) begin
			case (op)
				OP_SINGLE_BLOCK_LOCK: blk_lock[addr[21:16]] <= 1'b1;  // RQ12
				OP_SINGLE_BLOCK_UNLK: blk_lock[addr[21:16]] <= 1'b0;  // RQ12
				OP_GLOBAL_LOCK: blk_lock <= 64'hFFFF_FFFF_FFFF_FFFF;  // RQ13
				OP_GLOBAL_UNLOCK: blk_lock <= 64'h0000_0000_0000_0000;  // RQ13
				default: blk_lock <= blk_lock;
			endcase
		end
	end

	////////////////////////////////////////
	// Secured area

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			secured_mode <= 1'b0;
		end else if (cmd_ok && op == OP_ENTER_SECURED) begin
			secured_mode <= 1'b1;
		end else if (cmd_ok && op == OP_EXIT_SECURED) begin
			secured_mode <= 1'b0;
		end
	end

	// Locks only ever rise; no path clears them but reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fac_lock  <= 1'b0;
			cust_lock <= 1'b0;
		end else begin
			fac_lock  <= fac_lock | factory_lock_strap;  // RQ15 RQ18
			if (allowed && op == OP_SECURITY_REG_WRITE) begin
				cust_lock <= 1'b1;  // RQ17 RQ18
			end
		end
	end

	////////////////////////////////////////
	// Memory core requests

	logic      next_go;
	swp_kind_t next_kind;

	always_comb begin
		next_go   = 1'b0;
		next_kind = KIND_PROGRAM;
		if (allowed && is_prog) begin
			next_go = secured_mode ? !sec_locked : !prot_hit;  // RQ7 RQ18 RQ21
		end else if (allowed && is_erase && !secured_mode) begin  // RQ19
			case (op)
				OP_FOUR_KB_WIPE: next_kind = KIND_WIPE_4K;
				OP_HALF_BLOCK_ERASE: next_kind = KIND_ERASE_32;
				OP_BLOCK_ERASE: next_kind = KIND_ERASE_64;
				default: next_kind = KIND_CHIP;
			endcase
			if (op == OP_CHIP_ERASE) begin
				next_go = level == 4'h0;  // RQ14
			end else begin
				next_go = !prot_hit;  // RQ7 RQ21
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			op_go      <= 1'b0;
			op_kind    <= KIND_PROGRAM;
			op_addr    <= 22'h00_0000;
			op_data    <= 8'h00;
			op_secured <= 1'b0;
		end else begin
			op_go <= next_go;  // RQ2
			if (next_go) begin
				op_kind    <= next_kind;
				op_addr    <= addr;
				op_data    <= frame[4];
				op_secured <= secured_mode;
			end
		end
	end

	////////////////////////////////////////
	// Register port

	logic [31:0] status_word;
	logic [31:0] sec_word;
	logic [31:0] next_rdata;

	assign status_word = {22'h00_0000, protection_select_cmd, secured_mode, deep_sleep, top_bottom,
		status_lock, level, write_latch};
	assign sec_word    = {30'h0000_0000, cust_lock, fac_lock};  // RQ15

	always_comb begin
		case (reg_addr)
			REG_STATUS: next_rdata = status_word;
			REG_CTRL: next_rdata = {31'h0000_0000, quad_mode};
			REG_SECURITY: next_rdata = sec_word;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			quad_mode <= 1'b0;
		end else if (reg_wr && reg_addr == REG_CTRL) begin
			quad_mode <= reg_wdata[0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
		end
	end
endmodule

// >>> verification/swp_host_model.sv
/*
 SPI host model: sends mode 0 frames of a given bit count, MSB first.
 Assumes the core clk; the serial clock is 16 clk cycles long.
*/
`timescale 1ns/1ns
module swp_host_model (
	// Clock
	input  wire logic clk,
	// Serial pins
	output logic      sclk,
	output logic      cs_n,
	output logic      si
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si   = 1'b0;
	end

	// Sends the top nbits of data; a count off a byte makes a broken frame
	task automatic send(input logic [39:0] data, input int nbits);
		repeat (8) @(posedge clk);
		cs_n <= 1'b0;
		for (int i = 0; i < nbits; i++) begin
			repeat (4) @(posedge clk);
			si <= data[39 - i];
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
			repeat (8) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (8) @(posedge clk);
		cs_n <= 1'b1;
		// Released line has no pull, so it must not keep the last bit
		si <= ~si;
		repeat (24) @(posedge clk);
	endtask
endmodule

// >>> verification/swp_top_properties.sv
/*
 Port-level checks of the write-protection controller.
 Assumes it is bound to swp_top and sees its ports only.
*/
`timescale 1ns/1ns
module swp_top_properties import swp_pkg::*; (
	// Clock and reset
	input wire logic               clk,
	input wire logic               rst_n,
	// Serial pins and strap
	input wire logic               sclk,
	input wire logic               cs_n,
	input wire logic               si,
	input wire logic               write_protect_pin,
	input wire logic               factory_lock_strap,
	// Register port
	input wire logic [7:0]         reg_addr,
	input wire logic [31:0]        reg_wdata,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic [31:0]        reg_rdata,
	// Memory core request and state
	input wire logic               op_go,
	input wire swp_pkg::swp_kind_t op_kind,
	input wire logic [21:0]        op_addr,
	input wire logic [7:0]         op_data,
	input wire logic               op_secured,
	input wire logic               write_latch,
	input wire logic               deep_sleep,
	input wire logic               secured_mode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_reset_idle: assert property ($rose(rst_n) |-> !op_go && !write_latch && !deep_sleep)
		else $error("outputs not idle after reset");
	a_go_single: assert property (op_go |=> !op_go)
		else $error("request longer than one cycle");
	a_go_latch: assert property (op_go |-> $fell(write_latch))
		else $error("request without latch or latch not cleared");
	a_sleep_quiet: assert property (deep_sleep |-> !op_go)
		else $error("request while asleep");
	a_secured_target: assert property (op_go && secured_mode |-> op_secured)
		else $error("array reached in secured mode");
	a_secured_program: assert property (op_go && op_secured |-> op_kind == KIND_PROGRAM)
		else $error("erase aimed at secured area");
	a_read_window: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data outside its cycle");
	a_latch_framed: assert property ($rose(write_latch) |-> cs_n && $past(cs_n, 3))
		else $error("latch set inside a frame");
	a_factory_shown: assert property ($past(reg_rd) && $past(reg_addr) == REG_SECURITY
		&& $past(factory_lock_strap, 8) && $past(rst_n, 8) |-> reg_rdata[0])
		else $error("factory lock not reported");
endmodule

bind swp_top swp_top_properties i_props (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
	.si(si), .write_protect_pin(write_protect_pin), .factory_lock_strap(factory_lock_strap),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .op_go(op_go), .op_kind(op_kind), .op_addr(op_addr),
	.op_data(op_data), .op_secured(op_secured), .write_latch(write_latch),
	.deep_sleep(deep_sleep), .secured_mode(secured_mode));

// >>> verification/swp_top_test.sv
/*
 Self-checking bench of the write-protection controller.
 Assumes the design, its checker and the SPI host model are compiled first.
*/
`timescale 1ns/1ns
module swp_top_test;
	import swp_pkg::*;
	logic clk, rst_n, sclk, cs_n, si, write_protect_pin, factory_lock_strap;
	logic reg_wr, reg_rd, op_go, op_secured, write_latch, deep_sleep, secured_mode;
	logic [7:0] reg_addr, op_data;
	logic [31:0] reg_wdata, reg_rdata;
	logic [21:0] op_addr;
	swp_kind_t op_kind;
	int num_errors, checked, cycles, go_cnt, go_seen, lv, n, c1, c2;
	swp_byte_t ops[7] = '{OP_PAGE_PROGRAM, OP_QUAD_PAGE_PROGRAM, OP_CONT_PROGRAM,
		OP_FOUR_KB_WIPE, OP_HALF_BLOCK_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE};
	swp_kind_t kinds[7] = '{KIND_PROGRAM, KIND_PROGRAM, KIND_PROGRAM, KIND_WIPE_4K,
		KIND_ERASE_32, KIND_ERASE_64, KIND_CHIP};
	int lens[7] = '{40, 40, 40, 32, 32, 32, 8};

	swp_host_model i_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .si(si));
	swp_top i_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si),
		.write_protect_pin(write_protect_pin), .factory_lock_strap(factory_lock_strap),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .op_go(op_go), .op_kind(op_kind), .op_addr(op_addr),
		.op_data(op_data), .op_secured(op_secured), .write_latch(write_latch),
		.deep_sleep(deep_sleep), .secured_mode(secured_mode));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		if (num_errors == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask

	task automatic op1(input swp_byte_t op);
		i_host.send({op, 32'h0000_0000}, 8);
	endtask

	// Each command sent here is preceded by write-enable
	task automatic wcmd(input swp_byte_t op, input logic [31:0] rest, input int nb);
		op1(OP_WRITE_ENABLE);
		i_host.send({op, rest}, nb);
	endtask

	// Requests are counted, since the pulse lands while the host is still busy
	task automatic go(input logic exp, input swp_kind_t k);
		check(32'(go_cnt - go_seen), 32'(exp));
		go_seen = go_cnt;
		if (exp) begin
			check(32'(op_kind), 32'(k));
		end
		check(32'(write_latch), 32'h0000_0000);
	endtask

	task automatic erase(input int blk, input logic exp);
		wcmd(OP_BLOCK_ERASE, {2'b00, 6'(blk), 24'h00_0000}, 32);
		go(exp, KIND_ERASE_64);
	endtask

	task automatic prog(input logic [21:0] a, input logic exp);
		wcmd(OP_PAGE_PROGRAM, {2'b00, a, 8'h5A}, 40);
		go(exp, KIND_PROGRAM);
		if (exp) begin
			check(32'(op_addr), 32'(a));
		end
	endtask

	task automatic stat(input logic [7:0] b);
		wcmd(OP_STATUS_WRITE, {b, 24'h00_0000}, 16);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (op_go === 1'b1) begin
			go_cnt++;
		end
		cycles++;
		if (cycles == 95000) begin
			num_errors++;
			report_and_stop();
		end
	end

	initial begin
		rst_n              = 1'b0;
		write_protect_pin  = 1'b1;
		factory_lock_strap = 1'b0;
		reg_addr           = 8'h00;
		reg_wdata          = 32'h0000_0000;
		reg_wr             = 1'b0;
		reg_rd             = 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		rd(REG_STATUS, 32'h0000_0000);
		rd(REG_SECURITY, 32'h0000_0000);
		rd(8'h0C, 32'h0000_0000);
		wr(REG_CTRL, 32'h0000_0001);
		rd(REG_CTRL, 32'h0000_0001);
		wr(REG_CTRL, 32'h0000_0000);
		i_host.send({OP_PAGE_PROGRAM, 32'h2ABB_CCDD}, 40);
		go(1'b0, KIND_PROGRAM);
		wcmd(OP_PAGE_PROGRAM, 32'h2ABB_CCDD, 39);
		check(32'(go_cnt - go_seen), 32'h0000_0000);
		check(32'(write_latch), 32'h0000_0001);
		op1(OP_WRITE_DISABLE);
		check(32'(write_latch), 32'h0000_0000);
		foreach (ops[i]) begin
			wcmd(ops[i], 32'h2ABB_CCDD, lens[i]);
			go(1'b1, kinds[i]);
		end
		check(32'(op_addr), 32'h002A_BBCC);
		prog(22'h2A_BBCC, 1'b1);
		check(32'(op_data), 32'h0000_005A);
		for (int tb = 0; tb < 2; tb++) begin
			for (int lvl = 0; lvl < 9; lvl++) begin
				lv = (lvl == 8) ? 15 : lvl;
				stat({1'b0, 1'(tb), 4'(lv), 2'b00});
				rd(REG_STATUS, 32'(tb) << 6 | 32'(lv) << 1);
				n = (lv == 0) ? 0 : (lv >= 7) ? 64 : 1 << (lv - 1);
				c1 = tb ? n - 1 : 64 - n;
				c2 = tb ? n : 63 - n;
				if (c1 >= 0 && c1 < 64) erase(c1, 1'b0);
				if (c2 >= 0 && c2 < 64) erase(c2, 1'b1);
			end
		end
		wcmd(OP_CHIP_ERASE, 32'h0000_0000, 8);
		go(1'b0, KIND_CHIP);
		write_protect_pin <= 1'b0;
		stat(8'h80);
		rd(REG_STATUS, 32'h0000_0020);
		stat(8'h14);
		rd(REG_STATUS, 32'h0000_0020);
		wr(REG_CTRL, 32'h0000_0001);
		stat(8'h00);
		rd(REG_STATUS, 32'h0000_0000);
		wr(REG_CTRL, 32'h0000_0000);
		write_protect_pin <= 1'b1;
		wcmd(OP_PROTECTION_SELECT, 32'h0000_0000, 8);
		rd(REG_STATUS, 32'h0000_0201);
		wcmd(OP_SINGLE_BLOCK_LOCK, 32'h0500_0000, 32);
		erase(5, 1'b0);
		erase(6, 1'b1);
		wcmd(OP_SINGLE_BLOCK_UNLK, 32'h0500_0000, 32);
		erase(5, 1'b1);
		wcmd(OP_GLOBAL_LOCK, 32'h0000_0000, 8);
		erase(40, 1'b0);
		wcmd(OP_GLOBAL_UNLOCK, 32'h0000_0000, 8);
		erase(40, 1'b1);
		op1(OP_DEEP_SLEEP);
		check(32'(deep_sleep), 32'h0000_0001);
		op1(OP_WRITE_ENABLE);
		check(32'(write_latch), 32'h0000_0000);
		op1(OP_SLEEP_RELEASE);
		check(32'(deep_sleep), 32'h0000_0000);
		op1(OP_ENTER_SECURED);
		check(32'(secured_mode), 32'h0000_0001);
		erase(3, 1'b0);
		prog(22'h00_0005, 1'b1);
		check(32'(op_secured), 32'h0000_0001);
		wcmd(OP_SECURITY_REG_WRITE, 32'h0000_0000, 8);
		rd(REG_SECURITY, 32'h0000_0002);
		prog(22'h00_0010, 1'b0);
		prog(22'h00_000F, 1'b1);
		factory_lock_strap <= 1'b1;
		repeat (12) @(posedge clk);
		rd(REG_SECURITY, 32'h0000_0003);
		prog(22'h00_000F, 1'b0);
		op1(OP_EXIT_SECURED);
		prog(22'h00_0005, 1'b1);
		check(32'(op_secured), 32'h0000_0000);
		report_and_stop();
	end
endmodule
